/* design/pcd_port.sv */
// one gpio port: indexed configuration sub-registers and pin drive control
`timescale 1ns/1ps
module pcd_port
#(
  parameter int         WIDTH         = 8,    // pins in the port
  parameter logic [1:0] PORT_ID       = 2'h0, // 0 = a, 1 = b, 2 = c
  parameter bit         SMALL_PACKAGE = 1'b0  // shared reset and debug pins
)
(
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             addr_write,
  input  wire logic             ctl_write,
  input  wire logic             ctl_read,
  input  wire logic             addr_read,
  input  wire logic [7:0]       wdata,
  output logic      [7:0]       rdata,
  output logic                  rdata_valid,
  input  wire logic [WIDTH-1:0] gpio_data,
  input  wire pcd_pkg::pcd_alt_drv_s [WIDTH-1:0] alt,
  input  wire logic             timer_in_mode,
  input  wire logic             reset_seq,
  input  wire logic             debug_unlock,
  input  wire pcd_pkg::pcd_alt_drv_s debug_drv,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out,
  output logic      [WIDTH-1:0] pin_oe_n,
  output logic      [WIDTH-1:0] pin_level,
  output logic      [WIDTH-1:0] pin_high_drive,
  output logic      [WIDTH-1:0] alt_choice_low,
  output logic      [WIDTH-1:0] alt_choice_high,
  output logic      [2*WIDTH-1:0] led_level,
  output logic                  timer_capture,
  output logic                  reset_hold,
  output logic                  debug_pin_active
);
  import pcd_pkg::*;
  initial
  begin
    if (WIDTH < 7 || WIDTH > 8)
      $error("pcd_port: WIDTH must be 7 or 8");
  end
  localparam bit IS_A = (PORT_ID == PCD_PORT_A);
  localparam bit IS_B = (PORT_ID == PCD_PORT_B);
  localparam bit IS_C = (PORT_ID == PCD_PORT_C);
  localparam logic [WIDTH-1:0] AF_RESET = (IS_A && SMALL_PACKAGE) ?
                                          PCD_RST_AF_SMALL[WIDTH-1:0] : '0;
  // ========================================================================
  // sub-registers
  logic [7:0]       port_index;            // port address register
  logic [WIDTH-1:0] dir;                   // 1 = input
  logic [WIDTH-1:0] alt_function_enable;   // alternate function enable
  logic [WIDTH-1:0] open_drain;            // open-drain control
  logic [WIDTH-1:0] high_drive_enable_sub; // high current drive
  logic [WIDTH-1:0] recovery_enable;       // stored only
  logic [WIDTH-1:0] alt_select_low;        // first select
  logic [WIDTH-1:0] alt_select_high;       // second select, kept but unused
  logic [WIDTH-1:0] led_sink_enable;       // led drivers on
  logic [WIDTH-1:0] led_level_upper;       // level msb per pin
  logic [WIDTH-1:0] led_level_lower;       // level lsb per pin
  logic             debug_unlocked;        // sticky debug take-over
  // ========================================================================
  // decode of control-register writes to the indexed sub-register
  wire [WIDTH-1:0] wbits    = wdata[WIDTH-1:0];
  wire             wr_dir   = ctl_write && port_index == PCD_IDX_DIR;
  wire             wr_af    = ctl_write && port_index == PCD_IDX_AF;
  wire             wr_od    = ctl_write && port_index == PCD_IDX_OD;
  wire             wr_hd    = ctl_write && port_index == PCD_IDX_HD;
  wire             wr_smr   = ctl_write && port_index == PCD_IDX_SMR;
  wire             wr_alt_select_low  = ctl_write && port_index == PCD_IDX_ALT_SELECT_LOW;
  wire             wr_alt_select_high  = ctl_write && port_index == PCD_IDX_ALT_SELECT_HIGH;
  wire             wr_led_sink_enable = ctl_write && port_index == PCD_IDX_LED_EN && IS_C;
  wire             wr_ledup = ctl_write && port_index == PCD_IDX_LED_UP && IS_C;
  wire             wr_ledlo = ctl_write && port_index == PCD_IDX_LED_LO && IS_C;
  // read selection of the indexed sub-register, narrow ports pad with zero
  logic [WIDTH-1:0] sel_bits;
  logic             sel_hit;
  assign sel_hit  = (port_index == PCD_IDX_DIR)  || (port_index == PCD_IDX_AF)   ||
                    (port_index == PCD_IDX_OD)   || (port_index == PCD_IDX_HD)   ||
                    (port_index == PCD_IDX_SMR)  || (port_index == PCD_IDX_ALT_SELECT_LOW) ||
                    (port_index == PCD_IDX_ALT_SELECT_HIGH) ||
                    (IS_C && (port_index == PCD_IDX_LED_EN ||
                              port_index == PCD_IDX_LED_UP ||
                              port_index == PCD_IDX_LED_LO));
  assign sel_bits = (port_index == PCD_IDX_DIR)    ? dir                   :
                    (port_index == PCD_IDX_AF)     ? alt_function_enable   :
                    (port_index == PCD_IDX_OD)     ? open_drain            :
                    (port_index == PCD_IDX_HD)     ? high_drive_enable_sub :
                    (port_index == PCD_IDX_SMR)    ? recovery_enable       :
                    (port_index == PCD_IDX_ALT_SELECT_LOW)   ? alt_select_low        :
                    (port_index == PCD_IDX_ALT_SELECT_HIGH)   ? alt_select_high       :
                    (port_index == PCD_IDX_LED_EN) ? led_sink_enable       :
                    (port_index == PCD_IDX_LED_UP) ? led_level_upper       :
                                                     led_level_lower;
  wire [7:0] ctl_view = sel_hit ? 8'(sel_bits) : PCD_UNMAPPED;
  // ========================================================================
  // index register: holds until software writes it again
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      port_index <= PCD_RST_INDEX;
    else if (addr_write)
      port_index <= wdata;
  end
  // configuration sub-registers, each loads only when indexed
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      dir                   <= PCD_RST_DIR[WIDTH-1:0];
      alt_function_enable   <= AF_RESET;
      open_drain            <= PCD_RST_ZERO[WIDTH-1:0];
      high_drive_enable_sub <= PCD_RST_ZERO[WIDTH-1:0];
      recovery_enable       <= PCD_RST_ZERO[WIDTH-1:0];
      alt_select_low        <= PCD_RST_ZERO[WIDTH-1:0];
      alt_select_high       <= PCD_RST_ZERO[WIDTH-1:0];
    end
    else
    begin
      if (wr_dir)  dir                   <= wbits;
      if (wr_af)   alt_function_enable   <= wbits;
      if (wr_od)   open_drain            <= wbits;
      if (wr_hd)   high_drive_enable_sub <= wbits;
      if (wr_smr)  recovery_enable       <= wbits;
      if (wr_alt_select_low) alt_select_low        <= wbits;
      if (wr_alt_select_high) alt_select_high       <= wbits;
    end
  end
  // led control exists on port c only; elsewhere the writes never hit
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      led_sink_enable <= PCD_RST_ZERO[WIDTH-1:0];
      led_level_upper <= PCD_RST_ZERO[WIDTH-1:0];
      led_level_lower <= PCD_RST_ZERO[WIDTH-1:0];
    end
    else
    begin
      if (wr_led_sink_enable) led_sink_enable <= wbits;
      if (wr_ledup) led_level_upper <= wbits;
      if (wr_ledlo) led_level_lower <= wbits;
    end
  end
  // read data is registered so the answer is clean one cycle later
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      rdata       <= 8'h00;
      rdata_valid <= 1'b0;
    end
    else
    begin
      rdata_valid <= ctl_read | addr_read;
      if (addr_read)
        rdata <= port_index;
      else if (ctl_read)
        rdata <= ctl_view;
    end
  end
  // ========================================================================
  // shared debug pin: the unlock is only honoured inside the reset sequence,
  // so a stray pattern in normal running cannot steal the pin
  wire dbg_ok = SMALL_PACKAGE && IS_A;
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      debug_unlocked <= 1'b0;
    else if (dbg_ok && reset_seq && debug_unlock)
      debug_unlocked <= 1'b1;
  end
  assign debug_pin_active = debug_unlocked;
  // ========================================================================
  // per-pin configuration and drivers
  logic [WIDTH-1:0] led_active; // pin sinking led current
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_pin
      pcd_pin_cfg_s cfg;
      pcd_alt_drv_s drv;
      wire timer_pin = IS_A && (i == PCD_PIN_DEBUG || i == PCD_PIN_TIMER);
      wire dbg_pin   = (i == PCD_PIN_DEBUG) && debug_unlocked;
      // led mode: alternate function, select-low set, and driver enabled
      assign led_active[i] = IS_C && alt_function_enable[i] && alt_select_low[i]
                             && led_sink_enable[i];
      // timer pins in input mode drop the peripheral drive unless the unlocked debug drive owns pin 0; same configuration either way
      assign drv.data  = dbg_pin ? debug_drv.data : alt[i].data;
      assign drv.drive = dbg_pin ? debug_drv.drive :
                         (timer_pin && timer_in_mode) ? 1'b0 : alt[i].drive;
      assign cfg.is_input   = dir[i];
      assign cfg.use_alt    = alt_function_enable[i] || dbg_pin;
      assign cfg.open_drain = open_drain[i];
      assign cfg.led_mode   = led_active[i];
      // port b: select-low decides which of two functions, select-high ignored
      assign alt_choice_low[i]  = IS_B && alt_function_enable[i] && !alt_select_low[i];
      assign alt_choice_high[i] = IS_B && alt_function_enable[i] && alt_select_low[i];
      assign led_level[2*i+1:2*i] = led_active[i] ?
                                    {led_level_upper[i], led_level_lower[i]} : 2'b00;
      // high drive acts on the pad, whatever source drives it
      assign pin_high_drive[i] = high_drive_enable_sub[i];
      pcd_pin_cell u_cell
      (
        .clock     (clock),
        .reset     (reset),
        .cfg       (cfg),
        .gpio_data (gpio_data[i]),
        .alt       (drv),
        .pin_in    (pin_in[i]),
        .pin_out   (pin_out[i]),
        .pin_oe_n  (pin_oe_n[i]),
        .pin_level (pin_level[i])
      );
    end
  endgenerate
  // timer capture input follows the filtered pin 0 level on port a
  assign timer_capture = IS_A && timer_in_mode && pin_level[PCD_PIN_DEBUG];
  // a low level on the shared reset pin keeps the chip in reset
  assign reset_hold = SMALL_PACKAGE && IS_A && alt_function_enable[PCD_PIN_RESET]
                      && !pin_level[PCD_PIN_RESET];
  // ========================================================================
  // checks
  hd_index_a : assert property (@(posedge clock) disable iff (reset)
    ctl_write && port_index == PCD_IDX_HD |=> high_drive_enable_sub == $past(wbits))
    else $error("high drive sub-register missed indexed write");
  hd_pad_a : assert property (@(posedge clock) disable iff (reset)
    ctl_write && port_index == PCD_IDX_HD |=> pin_high_drive == $past(wbits))
    else $error("high drive not on pad after write");
  od_high_a : assert property (@(posedge clock) disable iff (reset)
    ((open_drain & pin_out & ~pin_oe_n) == '0))
    else $error("open-drain pin drives high");
  af_gate_a : assert property (@(posedge clock) disable iff (reset)
    (((alt_choice_low | alt_choice_high) & ~alt_function_enable) == '0))
    else $error("port b function without enable");
  led_sink_a : assert property (@(posedge clock) disable iff (reset)
    (((led_active & pin_out) | (led_active & pin_oe_n)) == '0))
    else $error("led pin not sinking");
  hold_pin_a : assert property (@(posedge clock) disable iff (reset)
    SMALL_PACKAGE && IS_A && alt_function_enable[PCD_PIN_RESET] &&
    $fell(pin_level[PCD_PIN_RESET]) |-> reset_hold)
    else $error("reset pin low without hold");
  debug_take_a : assert property (@(posedge clock) disable iff (reset)
    $rose(debug_pin_active) |-> $past(reset_seq) && $past(debug_unlock))
    else $error("debug pin taken outside reset sequence");
  index_keep_a : assert property (@(posedge clock) disable iff (reset)
    !addr_write ##1 !addr_write |-> $stable(port_index))
    else $error("port index changed without write");
endmodule // pcd_port

/* design/pcd_pkg.sv */
// package: sub-register indices, reset values and pin carriers for the port configuration block
// ==========================================================================
// Summary of operation
// - index 04h exposes high-drive sub-register via control
// - high-drive bit: 1 high current, 0 standard
// - high drive applies also under alternate function
// - open-drain bit 1 disables high-side driver
// - port b select-low bit picks function; select-high ignored
// - port b function needs alternate-function enable too
// - port a pins 0,6: timer mode picks input/output
// - port c led mode sinks at programmed level
// - small package pin a2 reverts to reset, holds
// - small package pin a0 becomes debug after unlock
package pcd_pkg;
  // ========================================================================
  // sub-register indices
  localparam logic [7:0] PCD_IDX_DIR      = 8'h01; // data direction, 1 = input
  localparam logic [7:0] PCD_IDX_AF       = 8'h02; // alt_function_enable
  localparam logic [7:0] PCD_IDX_OD       = 8'h03; // open-drain control
  localparam logic [7:0] PCD_IDX_HD       = 8'h04; // high_drive_enable_sub
  localparam logic [7:0] PCD_IDX_SMR      = 8'h05; // recovery source enable, storage only
  localparam logic [7:0] PCD_IDX_ALT_SELECT_LOW     = 8'h07; // alt_select_low
  localparam logic [7:0] PCD_IDX_ALT_SELECT_HIGH     = 8'h08; // alt_select_high
  localparam logic [7:0] PCD_IDX_LED_EN   = 8'h09; // led_sink_enable
  localparam logic [7:0] PCD_IDX_LED_UP   = 8'h0a; // led_level_upper
  localparam logic [7:0] PCD_IDX_LED_LO   = 8'h0b; // led_level_lower
  // ========================================================================
  // reset values
  localparam logic [7:0] PCD_RST_INDEX    = 8'h00;
  localparam logic [7:0] PCD_RST_DIR      = 8'hff;
  localparam logic [7:0] PCD_RST_ZERO     = 8'h00;
  localparam logic [7:0] PCD_RST_AF_SMALL = 8'h04; // pin 2 carries the reset function
  localparam logic [7:0] PCD_UNMAPPED     = 8'h00; // read value of unused indices
  // port identities
  localparam logic [1:0] PCD_PORT_A       = 2'h0;
  localparam logic [1:0] PCD_PORT_B       = 2'h1;
  localparam logic [1:0] PCD_PORT_C       = 2'h2;
  // pin positions with shared duties
  localparam int PCD_PIN_DEBUG  = 0;
  localparam int PCD_PIN_RESET  = 2;
  localparam int PCD_PIN_TIMER  = 6;
  // ========================================================================
  // per-pin configuration carried to the pin cell
  typedef struct packed {
    logic is_input;   // direction bit
    logic use_alt;    // alternate function drives the pin
    logic open_drain; // high side disabled
    logic led_mode;   // constant current sink active
  } pcd_pin_cfg_s;
  // peripheral-side drive request for one pin
  typedef struct packed {
    logic data;       // level wanted on the pin
    logic drive;      // peripheral wants to drive
  } pcd_alt_drv_s;
endpackage

/* design/pcd_pin_cell.sv */
// one port pin: input synchroniser and output driver selection
`timescale 1ns/1ps
module pcd_pin_cell
(
  input  wire logic                  clock,
  input  wire logic                  reset,
  input  wire pcd_pkg::pcd_pin_cfg_s cfg,
  input  wire logic                  gpio_data,
  input  wire pcd_pkg::pcd_alt_drv_s alt,
  input  wire logic                  pin_in,
  output logic                       pin_out,
  output logic                       pin_oe_n,
  output logic                       pin_level
);
  import pcd_pkg::*;
  // ========================================================================
  // input synchroniser, three stages; first stage feeds only the second
  logic sync_1;     // metastability catcher
  logic sync_2;     // second stage
  logic sync_3;     // third stage
  logic next_level; // filtered level
  // a change is accepted only once stages two and three agree
  assign next_level = (sync_2 == sync_3) ? sync_3 : pin_level;
  // stages reset high: an idle pulled-up pin
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      sync_1    <= 1'b1;
      sync_2    <= 1'b1;
      sync_3    <= 1'b1;
      pin_level <= 1'b1;
    end
    else
    begin
      sync_1    <= pin_in;
      sync_2    <= sync_1;
      sync_3    <= sync_2;
      pin_level <= next_level;
    end
  end
  // ========================================================================
  // driver selection
  logic want_drive; // some source asks to drive
  logic value;      // level asked for
  assign want_drive = cfg.led_mode | (cfg.use_alt ? alt.drive : ~cfg.is_input);
  assign value      = cfg.led_mode ? 1'b0 : (cfg.use_alt ? alt.data : gpio_data);
  // led sink pulls the cathode low; open drain only drives a low level
  assign pin_out    = value;
  assign pin_oe_n   = ~(want_drive & (~cfg.open_drain | ~value));
endmodule // pcd_pin_cell

/* verification/pcd_pin_partner.sv */
// partner model: external load on the port pins, a pull-up plus a switch to ground per pin
`timescale 1ns/1ps
// ==========================================================================
// pin load model
module pcd_pin_partner
(
  input  wire logic [7:0] pin_out,  // level the port drives
  input  wire logic [7:0] pin_oe_n, // low while the port drives
  input  wire logic [7:0] hold_low, // bench asks the load to clamp a pin to ground
  output logic      [7:0] pin_in    // resolved pad level fed back to the port
);
  // an undriven pin floats up through the pull-up, never holding a stale level
  // limitation: a port driving high against a clamped pin is not flagged as contention
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (hold_low[i])
        pin_in[i] = 1'b0;        // external low wins, like a held reset switch
      else if (!pin_oe_n[i])
        pin_in[i] = pin_out[i];  // port owns the wire
      else
        pin_in[i] = 1'b1;        // pull-up level
    end
  end
endmodule // pcd_pin_partner

/* verification/tb.sv */
// testbench: a port b, a small-package port a and a port c, all driven through the register strobes
`timescale 1ns/1ps
// ==========================================================================
// top level
module tb;
  import pcd_pkg::*;
  logic               clock        = 1'b0;  // 10 mhz system clock
  logic               reset        = 1'b1;  // async, active high
  logic               addr_write   = 1'b0;  // index write strobe
  logic               ctl_write    = 1'b0;  // sub-register write strobe
  logic               ctl_read     = 1'b0;  // sub-register read strobe
  logic               addr_read    = 1'b0;  // index read strobe
  logic               reset_seq    = 1'b0;  // reset sequence window
  logic               debug_unlock = 1'b0;  // unlock pulse from debug logic
  logic [7:0]         wdata        = 8'h00; // shared write data
  logic [7:0]         gpio_data    = 8'h00; // output data per pin
  logic [7:0]         hold_b       = 8'h00; // ground clamp on port b pins
  logic [7:0]         hold_a       = 8'h00; // ground clamp on port a pins
  pcd_alt_drv_s [7:0] alt          = '0;    // peripheral drive requests
  logic [7:0]         rdata;                // port b read data
  logic               rdata_valid;          // port b read strobe back
  logic [7:0]         pin_in, pin_out, pin_oe_n, pin_level, pin_high_drive;
  logic [7:0]         alt_choice_low, alt_choice_high;
  logic [7:0]         pin_in_a, out_a, oe_n_a;
  logic               reset_hold_a, debug_active_a;
  logic               timer_capture_a;      // port a timer input
  logic               timer_mode   = 1'b0;  // port a timer pins used as input
  pcd_alt_drv_s       debug_drv    = '0;    // debug drive for port a pin 0
  logic [7:0]         out_c, oe_n_c;        // port c pad, looped back as its input
  logic [15:0]        led_level_c;          // port c led level codes
  int                 miscompares  = 0;
  int                 comparisons  = 0;
  // ========================================================================
  // clock and devices
  always #50 clock = ~clock;
  // all three ports share the strobes, so a write lands in all three at once
  pcd_port #(.WIDTH(8), .PORT_ID(PCD_PORT_B), .SMALL_PACKAGE(1'b0)) i_dut
  (
    .clock(clock), .reset(reset), .addr_write(addr_write), .ctl_write(ctl_write),
    .ctl_read(ctl_read), .addr_read(addr_read), .wdata(wdata), .rdata(rdata),
    .rdata_valid(rdata_valid), .gpio_data(gpio_data), .alt(alt), .timer_in_mode(timer_mode),
    .reset_seq(reset_seq), .debug_unlock(debug_unlock), .debug_drv(debug_drv), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_level(pin_level),
    .pin_high_drive(pin_high_drive), .alt_choice_low(alt_choice_low),
    .alt_choice_high(alt_choice_high), .led_level(), .timer_capture(), .reset_hold(),
    .debug_pin_active()
  );
  pcd_port #(.WIDTH(8), .PORT_ID(PCD_PORT_A), .SMALL_PACKAGE(1'b1)) i_dut_a
  (
    .clock(clock), .reset(reset), .addr_write(addr_write), .ctl_write(ctl_write),
    .ctl_read(ctl_read), .addr_read(addr_read), .wdata(wdata), .rdata(),
    .rdata_valid(), .gpio_data(gpio_data), .alt(alt), .timer_in_mode(timer_mode),
    .reset_seq(reset_seq), .debug_unlock(debug_unlock), .debug_drv(debug_drv),
    .pin_in(pin_in_a), .pin_out(out_a), .pin_oe_n(oe_n_a), .pin_level(), .pin_high_drive(),
    .alt_choice_low(), .alt_choice_high(), .led_level(), .timer_capture(timer_capture_a),
    .reset_hold(reset_hold_a), .debug_pin_active(debug_active_a)
  );
  pcd_pin_partner i_load_b (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .hold_low(hold_b),
                            .pin_in(pin_in));
  pcd_pin_partner i_load_a (.pin_out(out_a), .pin_oe_n(oe_n_a), .hold_low(hold_a),
                            .pin_in(pin_in_a));
  // port c carries the led sink; its pads need no load, they read back their own level
  pcd_port #(.WIDTH(8), .PORT_ID(PCD_PORT_C), .SMALL_PACKAGE(1'b0)) i_dut_c
  (
    .clock(clock), .reset(reset), .addr_write(addr_write), .ctl_write(ctl_write),
    .ctl_read(ctl_read), .addr_read(addr_read), .wdata(wdata), .rdata(), .rdata_valid(),
    .gpio_data(gpio_data), .alt(alt), .timer_in_mode(timer_mode), .reset_seq(reset_seq),
    .debug_unlock(debug_unlock), .debug_drv(debug_drv), .pin_in(out_c), .pin_out(out_c),
    .pin_oe_n(oe_n_c), .pin_level(), .pin_high_drive(), .alt_choice_low(),
    .alt_choice_high(), .led_level(led_level_c), .timer_capture(), .reset_hold(),
    .debug_pin_active()
  );
  // ========================================================================
  // shared tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t %s: saw %h expected %h", $time, what, seen, exp);
    end
  endtask
  // one write, strobe held across exactly one rising edge
  task automatic put(input bit to_index, input logic [7:0] value);
    @(negedge clock);
    addr_write = to_index;
    ctl_write  = !to_index;
    wdata      = value;
    @(negedge clock);
    addr_write = 1'b0;
    ctl_write  = 1'b0;
  endtask
  // one read; data and valid are looked at in the single cycle that valid stands
  task automatic get(input bit from_index, input logic [7:0] exp, input string what);
    @(negedge clock);
    addr_read = from_index;
    ctl_read  = !from_index;
    @(negedge clock);
    addr_read = 1'b0;
    ctl_read  = 1'b0;
    check({7'h00, rdata_valid}, 8'h01, "read valid");
    check(rdata, exp, what);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ========================================================================
  // scenarios
  task automatic test_reset_values();
    get(1'b1, PCD_RST_INDEX, "index after reset");
    check(pin_high_drive, PCD_RST_ZERO, "high drive reset");
    check(pin_oe_n, 8'hff, "pins released");
    check({7'h00, oe_n_a[0]}, 8'h01, "shared debug pin is input");
    check({7'h00, reset_hold_a}, 8'h00, "reset pin high, no hold");
    put(1'b1, PCD_IDX_HD);
    get(1'b0, PCD_RST_ZERO, "high drive read at reset");
    $display("test reset_values done");
  endtask
  // unlock outside the window is ignored; inside it the pin is handed over
  task automatic test_debug_unlock();
    @(negedge clock);
    debug_unlock = 1'b1;
    @(negedge clock);
    debug_unlock = 1'b0;
    reset_seq    = 1'b1;
    repeat (2) @(negedge clock);
    check({7'h00, debug_active_a}, 8'h00, "unlock outside window");
    debug_unlock = 1'b1;
    @(negedge clock);
    debug_unlock = 1'b0;
    reset_seq    = 1'b0;
    repeat (2) @(negedge clock);
    check({7'h00, debug_active_a}, 8'h01, "unlock inside window");
    $display("test debug_unlock done");
  endtask
  // index written once, two data writes through it without rewriting
  task automatic test_high_drive();
    put(1'b1, PCD_IDX_HD);
    put(1'b0, 8'h5a);
    check(pin_high_drive, 8'h5a, "high drive bits");
    put(1'b0, 8'ha5);
    check(pin_high_drive, 8'ha5, "high drive rewrite");
    get(1'b0, 8'ha5, "high drive readback");
    get(1'b1, PCD_IDX_HD, "index persists");
    $display("test high_drive done");
  endtask
  task automatic test_open_drain();
    put(1'b1, PCD_IDX_DIR);
    put(1'b0, 8'hfd);
    gpio_data = 8'h02;
    repeat (5) @(negedge clock);
    check({6'h00, pin_out[1], pin_oe_n[1]}, 8'h02, "push-pull high");
    put(1'b1, PCD_IDX_OD);
    put(1'b0, 8'h02);
    repeat (5) @(negedge clock);
    check({7'h00, pin_oe_n[1]}, 8'h01, "open drain releases high");
    check({7'h00, pin_level[1]}, 8'h01, "pull-up seen");
    gpio_data = 8'h00;
    repeat (5) @(negedge clock);
    check({6'h00, pin_out[1], pin_oe_n[1]}, 8'h00, "open drain sinks low");
    check({7'h00, pin_level[1]}, 8'h00, "low seen");
    $display("test open_drain done");
  endtask
  task automatic test_alt_select();
    // both selects are written before the enable
    put(1'b1, PCD_IDX_ALT_SELECT_LOW);
    put(1'b0, 8'h20);
    put(1'b1, PCD_IDX_ALT_SELECT_HIGH);
    put(1'b0, 8'hff);
    check(alt_choice_low | alt_choice_high, 8'h00, "no enable yet");
    alt[0] = '{data: 1'b1, drive: 1'b1};
    put(1'b1, PCD_IDX_AF);
    put(1'b0, 8'h29);
    check(alt_choice_low, 8'h09, "select low choices");
    check(alt_choice_high, 8'h20, "select high ignored");
    check({5'h00, pin_out[0], pin_oe_n[0], pin_high_drive[0]}, 8'h05, "alt drive");
    put(1'b1, PCD_IDX_LED_EN);
    put(1'b0, 8'hff);
    get(1'b0, PCD_UNMAPPED, "led index absent on port b");
    // port c pin 5 now has enable, select-low and led driver: code {1,0} sinks
    put(1'b1, PCD_IDX_LED_UP);
    put(1'b0, 8'h20);
    check({4'h0, led_level_c[11:10], out_c[5], oe_n_c[5]}, 8'h08, "led sink level");
    $display("test alt_select done");
  endtask
  // timer pin 6 drives only in output mode; an unlocked debug drive owns pin 0
  task automatic test_timer_debug();
    alt[6] = '{data: 1'b1, drive: 1'b1};
    put(1'b1, PCD_IDX_AF);
    put(1'b0, 8'h40);
    check({6'h00, out_a[6], oe_n_a[6]}, 8'h02, "timer output drives");
    timer_mode = 1'b1;
    debug_drv  = '{data: 1'b0, drive: 1'b1};
    repeat (5) @(negedge clock);
    check({7'h00, oe_n_a[6]}, 8'h01, "timer input released");
    check({6'h00, oe_n_a[0], timer_capture_a}, 8'h00, "debug drives pin low");
    debug_drv  = '0;
    repeat (5) @(negedge clock);
    check({7'h00, timer_capture_a}, 8'h01, "capture follows pin");
    timer_mode = 1'b0;
    $display("test timer_debug done");
  endtask
  // software frees the reset pin; a system reset must give it back
  task automatic test_reset_pin();
    hold_a = 8'h04;
    repeat (6) @(negedge clock);
    check({7'h00, reset_hold_a}, 8'h00, "freed pin ignores low");
    reset = 1'b1;
    @(negedge clock);
    reset = 1'b0;
    repeat (6) @(negedge clock);
    check({7'h00, reset_hold_a}, 8'h01, "reset function restored");
    check({7'h00, debug_active_a}, 8'h00, "debug cleared by reset");
    check(pin_high_drive, PCD_RST_ZERO, "high drive cleared");
    hold_a = 8'h00;
    repeat (6) @(negedge clock);
    check({7'h00, reset_hold_a}, 8'h00, "released pin");
    $display("test reset_pin done");
  endtask
  // ========================================================================
  // main sequence and watchdog
  initial
  begin
    repeat (4) @(negedge clock);
    reset = 1'b0;
    test_reset_values();
    test_debug_unlock();
    test_high_drive();
    test_open_drain();
    test_alt_select();
    test_timer_debug();
    test_reset_pin();
    give_verdict();
  end
  // whole run is well under 200 cycles; ten times that means a hang
  initial
  begin
    repeat (2000) @(posedge clock);
    miscompares++;
    $display("[FAIL] %0t watchdog expired", $time);
    give_verdict();
  end
endmodule // tb
